/* File: hw/loop_adjust_pkg.sv */
// constants for the loop output adjust and housekeeping block
package loop_adjust_pkg;
  // register indices (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_OUTPUT_ADJUST = 8'h2d;
  localparam logic [7:0] IDX_HOUSEKEEPING = 8'h2e;
  localparam logic [7:0] IDX_INT_STATUS = 8'h30;
  localparam logic [7:0] IDX_INT_MASK = 8'h31;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_ADJUST = {IDX_OUTPUT_ADJUST, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HOUSEKEEPING = {IDX_HOUSEKEEPING, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = {IDX_INT_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = {IDX_INT_MASK, 2'b00};
  localparam logic [15:0] RESET_OUTPUT_ADJUST = 16'h0000;
  localparam logic [15:0] RESET_HOUSEKEEPING = 16'h0000;
  // output adjust fields
  localparam int PHASE_LSB = 9;
  localparam int PHASE_W = 7;
  localparam int SKEW_LSB = 0;
  localparam int SKEW_W = 3;
  localparam logic [15:0] ADJUST_WR_MASK = 16'hfe07;
  // housekeeping fields
  localparam int HK_STATE_LSB = 0;
  localparam int HK_LIMIT_BIT = 3;
  localparam int HK_RATE_BIT = 4;
  localparam int HK_PRI_LOSS_BIT = 5;
  localparam int HK_SEC_LOSS_BIT = 6;
  // interrupt event bits
  localparam int EV_PRI_LOSS = 0;
  localparam int EV_SEC_LOSS = 1;
  localparam int EV_LIMIT = 2;
  localparam int EV_STATE = 3;
  localparam int EV_W = 4;
  // timing and bus response codes
  localparam real CLK_PERIOD_NS = 40.0;
  localparam real SKEW_STEP_NS = 3.5;
  localparam int SKEW_MAX_STEPS = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: hw/skew_delay_line.sv */
// per-tap delay line for the skewed fast clock output
`timescale 1ns/100ps
module skew_delay_line
  import loop_adjust_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  input wire logic [SKEW_W-1:0] sel,
  output logic q
);
  // one register per tap; on this clock a tap is far coarser than the pad-level step
  logic [SKEW_MAX_STEPS:0] tap_ff;
  logic [SKEW_MAX_STEPS:0] nxt_tap;
  logic nxt_q;
  logic q_ff;

  always_comb begin
    nxt_tap = tap_ff;
    nxt_tap[0] = d;
    for (int i = 1; i <= SKEW_MAX_STEPS; i++) begin
      nxt_tap[i] = tap_ff[i-1];
    end
    nxt_q = tap_ff[sel];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tap_ff <= '0;
      q_ff <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule

/* File: hw/loop_output_adjust_regs.sv */
// loop output adjust and housekeeping registers with AXI4-Lite slave
`timescale 1ns/100ps
module loop_output_adjust_regs
  import loop_adjust_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic FAST_CLK_HI,
  input wire logic FAST_CLK_LO,
  input wire logic PRI_LOSS,
  input wire logic SEC_LOSS,
  input wire logic SLOPE_LIMIT,
  input wire logic [2:0] LOOP_STATE,
  output logic PRIMARY_FAST_CLOCK_OUTPUT,
  output logic [PHASE_W-1:0] PHASE_OFFSET_FIELD,
  output logic [SKEW_W-1:0] SKEW_CODE,
  output logic IRQ
);
  // ****************************************
  // status input synchronisers
  // ****************************************
  // three stages; a change counts once stages two and three agree
  logic [5:0] s1_ff, s2_ff, s3_ff, stat_ff;
  logic [5:0] nxt_stat;
  logic [5:0] stat_in;

  assign stat_in = {LOOP_STATE, SLOPE_LIMIT, SEC_LOSS, PRI_LOSS};

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      nxt_stat[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : stat_ff[i];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      stat_ff <= '0;
    end else begin
      s1_ff <= stat_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stat_ff <= nxt_stat;
    end
  end

  logic pri_loss, sec_loss, limit_act;
  logic [2:0] loop_state;
  assign pri_loss = stat_ff[0];
  assign sec_loss = stat_ff[1];
  assign limit_act = stat_ff[2];
  assign loop_state = stat_ff[5:3];

  // ****************************************
  // axi4-lite slave and registers
  // ****************************************
  logic [15:0] adjust_ff, nxt_adjust;
  logic rate_ff, nxt_rate;
  logic [EV_W-1:0] ev_stat_ff, nxt_ev_stat;
  logic [EV_W-1:0] ev_mask_ff, nxt_ev_mask;
  logic aw_ok_ff, nxt_aw_ok;
  logic w_ok_ff, nxt_w_ok;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [5:0] prev_ff;
  logic [EV_W-1:0] events;
  logic [15:0] hk_word;
  logic [15:0] wr16;
  logic irq_ff, nxt_irq;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic arready_ff, nxt_arready;

  // edges of the filtered status raise sticky events
  assign events = {stat_ff[5:3] != prev_ff[5:3], limit_act & ~prev_ff[2],
                   sec_loss & ~prev_ff[1], pri_loss & ~prev_ff[0]};

  always_comb begin
    hk_word = '0;
    hk_word[HK_STATE_LSB +: 3] = loop_state;
    hk_word[HK_LIMIT_BIT] = limit_act;
    hk_word[HK_RATE_BIT] = rate_ff;
    hk_word[HK_PRI_LOSS_BIT] = pri_loss;
    hk_word[HK_SEC_LOSS_BIT] = sec_loss;
  end

  // merge byte lanes of the 16-bit registers
  function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  always_comb begin
    nxt_aw_ok = aw_ok_ff;
    nxt_w_ok = w_ok_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_adjust = adjust_ff;
    nxt_rate = rate_ff;
    nxt_ev_mask = ev_mask_ff;
    nxt_ev_stat = ev_stat_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    wr16 = '0;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      nxt_aw_ok = 1'b1;
      nxt_awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      nxt_w_ok = 1'b1;
      nxt_wdata = S_AXI_WDATA;
      nxt_wstrb = S_AXI_WSTRB;
    end
    if (aw_ok_ff && w_ok_ff && !bvalid_ff) begin
      nxt_aw_ok = 1'b0;
      nxt_w_ok = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      case (awaddr_ff[ADDR_W-1:2])
        IDX_OUTPUT_ADJUST: begin
          wr16 = lanes(adjust_ff, wdata_ff, wstrb_ff);
          nxt_adjust = wr16 & ADJUST_WR_MASK; // reserved bits stay zero
        end
        IDX_HOUSEKEEPING: begin
          wr16 = lanes({11'h000, rate_ff, 4'h0}, wdata_ff, wstrb_ff);
          nxt_rate = wr16[HK_RATE_BIT];
        end
        IDX_INT_MASK: begin
          wr16 = lanes({12'h000, ev_mask_ff}, wdata_ff, wstrb_ff);
          nxt_ev_mask = wr16[EV_W-1:0];
        end
        IDX_INT_STATUS: ;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && S_AXI_BREADY) nxt_bvalid = 1'b0;
    if (rvalid_ff && S_AXI_RREADY) nxt_rvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = '0;
      case (S_AXI_ARADDR[ADDR_W-1:2])
        IDX_OUTPUT_ADJUST: nxt_rdata = {16'h0000, adjust_ff};
        IDX_HOUSEKEEPING: nxt_rdata = {16'h0000, hk_word};
        IDX_INT_STATUS: begin
          nxt_rdata = {28'h0000000, ev_stat_ff};
          nxt_ev_stat = '0; // read clears
        end
        IDX_INT_MASK: nxt_rdata = {28'h0000000, ev_mask_ff};
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
    // a new event wins over a clearing read in the same cycle
    nxt_ev_stat = nxt_ev_stat | events;
    nxt_irq = |(nxt_ev_stat & nxt_ev_mask);
    // readies come from the next slot state, so they leave a flop with no extra cycle
    nxt_awready = !nxt_aw_ok && !nxt_bvalid;
    nxt_wready = !nxt_w_ok && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      adjust_ff <= RESET_OUTPUT_ADJUST;
      rate_ff <= RESET_HOUSEKEEPING[HK_RATE_BIT];
      ev_mask_ff <= '0;
      ev_stat_ff <= '0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
      prev_ff <= '0;
      irq_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
    end else begin
      aw_ok_ff <= nxt_aw_ok;
      w_ok_ff <= nxt_w_ok;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      adjust_ff <= nxt_adjust;
      rate_ff <= nxt_rate;
      ev_mask_ff <= nxt_ev_mask;
      ev_stat_ff <= nxt_ev_stat;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      prev_ff <= stat_ff;
      irq_ff <= nxt_irq;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
    end
  end

  // ready only when the slot is empty, so one write is held at a time
  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY = wready_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign IRQ = irq_ff;
  assign PHASE_OFFSET_FIELD = adjust_ff[PHASE_LSB +: PHASE_W];
  assign SKEW_CODE = adjust_ff[SKEW_LSB +: SKEW_W];

  // ****************************************
  // fast clock rate select and skew
  // ****************************************
  // rate inputs are assumed to be on CLK already (divided/enabled by the loop)
  logic fast_sel;
  assign fast_sel = rate_ff ? FAST_CLK_HI : FAST_CLK_LO;

  skew_delay_line u_skew (
    .clk(CLK),
    .rst_n(RST_N),
    .d(fast_sel),
    .sel(adjust_ff[SKEW_LSB +: SKEW_W]),
    .q(PRIMARY_FAST_CLOCK_OUTPUT)
  );
endmodule

/* File: tb/loop_adjust_monitor.sv */
// assertion checker for the loop adjust register block
`timescale 1ns/100ps
module loop_adjust_monitor
  import loop_adjust_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic FAST_CLK_HI,
  input wire logic FAST_CLK_LO,
  input wire logic PRI_LOSS,
  input wire logic SEC_LOSS,
  input wire logic SLOPE_LIMIT,
  input wire logic [2:0] LOOP_STATE,
  input wire logic PRIMARY_FAST_CLOCK_OUTPUT,
  input wire logic [SKEW_W-1:0] SKEW_CODE
);
  // ****************
  // helper state
  // ****************
  // status pins reach the register a few cycles late, so compare only once settled
  logic hk_ff, nxt_hk;
  logic [3:0] st_ff, nxt_st;
  logic [5:0] in_ff;
  logic [5:0] cur;
  assign cur = {PRI_LOSS, SEC_LOSS, SLOPE_LIMIT, LOOP_STATE};
  always_comb begin
    nxt_hk = hk_ff;
    if (S_AXI_ARVALID && S_AXI_ARREADY) nxt_hk = S_AXI_ARADDR == ADDR_HOUSEKEEPING;
    nxt_st = (in_ff != cur) ? 4'h0 : ((st_ff == 4'hf) ? st_ff : st_ff + 4'h1);
  end
  always_ff @(posedge CLK) begin
    hk_ff <= RST_N ? nxt_hk : 1'h0;
    st_ff <= RST_N ? nxt_st : 4'h0;
    in_ff <= cur;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_sk0;
    (SKEW_CODE == 3'h0)[*8] |-> PRIMARY_FAST_CLOCK_OUTPUT == $past(FAST_CLK_HI, 2)
      || PRIMARY_FAST_CLOCK_OUTPUT == $past(FAST_CLK_LO, 2);
  endproperty
  a_sk0: assert property (p_sk0) else $error("skew zero delay wrong");
  property p_sk3;
    (SKEW_CODE == 3'h3)[*8] |-> PRIMARY_FAST_CLOCK_OUTPUT == $past(FAST_CLK_HI, 5)
      || PRIMARY_FAST_CLOCK_OUTPUT == $past(FAST_CLK_LO, 5);
  endproperty
  a_sk3: assert property (p_sk3) else $error("skew three delay wrong");
  property p_sk7;
    (SKEW_CODE == 3'h7)[*8] |-> PRIMARY_FAST_CLOCK_OUTPUT == $past(FAST_CLK_HI, 9)
      || PRIMARY_FAST_CLOCK_OUTPUT == $past(FAST_CLK_LO, 9);
  endproperty
  a_sk7: assert property (p_sk7) else $error("skew seven delay wrong");
  property p_lim;
    $rose(S_AXI_RVALID) && hk_ff && st_ff > 4'h8 |-> S_AXI_RDATA[3] == SLOPE_LIMIT;
  endproperty
  a_lim: assert property (p_lim) else $error("limit bit wrong");
  property p_st;
    $rose(S_AXI_RVALID) && hk_ff && st_ff > 4'h8
      |-> S_AXI_RDATA[6:5] == {SEC_LOSS, PRI_LOSS} && S_AXI_RDATA[2:0] == LOOP_STATE;
  endproperty
  a_st: assert property (p_st) else $error("state or loss bits wrong");
  property p_ro;
    $rose(S_AXI_RVALID) && hk_ff |-> S_AXI_RDATA[31:7] == 25'h0;
  endproperty
  a_ro: assert property (p_ro) else $error("reserved bits set");
  property p_rl;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rl: assert property (p_rl) else $error("read answer late");
  property p_rst;
    $rose(RST_N) |-> !PRIMARY_FAST_CLOCK_OUTPUT;
  endproperty
  a_rst: assert property (p_rst) else $error("output not idle after reset");
endmodule

/* File: tb/loop_output_adjust_regs_test.sv */
// self-checking bench for the loop adjust register block
`timescale 1ns/100ps
module loop_output_adjust_regs_test;
  import loop_adjust_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic hi = 1'h0, lo = 1'h0, pri = 1'h0, sec = 1'h0, lim = 1'h0, rnd = 1'h0;
  logic [9:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic [2:0] st = '0;
  logic awr, wrd, bv, arr, rv, fo, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] sk;
  logic [6:0] ph;
  logic [65:0] e;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  int failures = 0, cmp_count = 0, k;
  always #20 clk = ~clk;
  loop_output_adjust_regs dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .FAST_CLK_HI(hi), .FAST_CLK_LO(lo), .PRI_LOSS(pri), .SEC_LOSS(sec),
    .SLOPE_LIMIT(lim), .LOOP_STATE(st), .PRIMARY_FAST_CLOCK_OUTPUT(fo),
    .PHASE_OFFSET_FIELD(ph), .SKEW_CODE(sk), .IRQ(irq));
  // ****************
  // checking and bus tasks
  // ****************
  task chk(input logic [31:0] g, input logic [31:0] x, input logic [31:0] m);
    cmp_count++;
    if ((g & m) !== (x & m)) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask
  task report_and_stop;
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // both channels offered together; the loop bound is the only limit on the answer
  task wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    for (k = 0; k < 40 && !(bv && bry); k++) begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
    end
    bry <= 1'h0;
    if (k == 40) begin failures++; report_and_stop; end
    @(posedge clk);
  endtask
  task rd(input logic [9:0] a, input logic [31:0] x, input logic [31:0] m, input logic [1:0] r);
    rq.push_back({m, r, x});
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    for (k = 0; k < 40 && !(rv && rry); k++) begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
    end
    rry <= 1'h0;
    if (k == 40) begin failures++; report_and_stop; end
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (bv && bry) chk({30'h0, bresp}, {30'h0, bq.pop_front()}, 32'h3);
    if (rv && rry) begin
      e = rq.pop_front();
      chk(rdata, e[31:0], e[65:34]);
      chk({30'h0, rresp}, {30'h0, e[33:32]}, 32'h3);
    end
    // sole driver of the rate sources: fixed high/low levels make the rate mux visible
    if (rnd) {hi, lo} <= 2'($urandom);
    else {hi, lo} <= 2'h2;
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    k = $urandom(1);
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(ADDR_OUTPUT_ADJUST, 32'h0, '1, RESP_OKAY);
    rd(ADDR_HOUSEKEEPING, 32'h0, '1, RESP_OKAY);
    rnd <= 1'h1;
    wr(ADDR_OUTPUT_ADJUST, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_OUTPUT_ADJUST, 32'hfe07, '1, RESP_OKAY);
    chk({29'h0, sk}, 32'h7, '1);
    chk({25'h0, ph}, 32'h7f, '1);
    repeat (20) @(posedge clk);
    wr(ADDR_OUTPUT_ADJUST, 32'h3, RESP_OKAY);
    chk({29'h0, sk}, 32'h3, '1);
    chk({25'h0, ph}, 32'h0, '1);
    repeat (20) @(posedge clk);
    wr(ADDR_OUTPUT_ADJUST, 32'h0, RESP_OKAY);
    repeat (20) @(posedge clk);
    rnd <= 1'h0;
    wr(ADDR_HOUSEKEEPING, 32'hffff_ffff, RESP_OKAY);
    repeat (12) @(posedge clk);
    chk({31'h0, fo}, 32'h1, '1);
    wr(ADDR_HOUSEKEEPING, 32'hffff_ffef, RESP_OKAY);
    repeat (12) @(posedge clk);
    chk({31'h0, fo}, 32'h0, '1);
    for (int i = 0; i < 6; i++) begin
      {pri, sec, lim, st} <= 6'($urandom);
      wr(ADDR_HOUSEKEEPING, {27'h7ff_ffff, i[0], 4'hf}, RESP_OKAY);
      repeat (10) @(posedge clk);
      rd(ADDR_HOUSEKEEPING, {25'h0, sec, pri, i[0], lim, st}, '1, RESP_OKAY);
    end
    rd(10'h3fc, 32'h0, '1, RESP_SLVERR);
    wr(10'h3fc, 32'h1, RESP_SLVERR);
    // events are sticky, so flush whatever the random phase left behind
    {pri, sec, lim, st} <= 6'h0;
    wr(ADDR_INT_MASK, 32'h1, RESP_OKAY);
    repeat (10) @(posedge clk);
    rd(ADDR_INT_STATUS, 32'h0, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, '1);
    pri <= 1'h1;
    repeat (10) @(posedge clk);
    chk({31'h0, irq}, 32'h1, '1);
    rd(ADDR_INT_STATUS, 32'h1, 32'hf, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, '1);
    sec <= 1'h1;
    repeat (10) @(posedge clk);
    chk({31'h0, irq}, 32'h0, '1);
    rd(ADDR_INT_STATUS, 32'h2, 32'hf, RESP_OKAY);
    lim <= 1'h1;
    repeat (10) @(posedge clk);
    rd(ADDR_INT_STATUS, 32'h4, 32'hf, RESP_OKAY);
    st <= 3'h5;
    repeat (10) @(posedge clk);
    rd(ADDR_INT_STATUS, 32'h8, 32'hf, RESP_OKAY);
    rd(ADDR_INT_MASK, 32'h1, '1, RESP_OKAY);
    report_and_stop;
  end
endmodule
bind loop_output_adjust_regs loop_adjust_monitor mon (.CLK(CLK), .RST_N(RST_N),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA),
  .FAST_CLK_HI(FAST_CLK_HI), .FAST_CLK_LO(FAST_CLK_LO), .PRI_LOSS(PRI_LOSS),
  .SEC_LOSS(SEC_LOSS), .SLOPE_LIMIT(SLOPE_LIMIT), .LOOP_STATE(LOOP_STATE),
  .PRIMARY_FAST_CLOCK_OUTPUT(PRIMARY_FAST_CLOCK_OUTPUT), .SKEW_CODE(SKEW_CODE));
